// ---- hdl/ppcd_top.v ----
// per-phase phase, gain and offset correction of the computed powers
// Functional notes
// - phase correction steps are whole 1.024 MHz samples, each 360*f/1.024MHz degrees.
// - bit value 512 of the phase correction marks a positive error, the low bits hold magnitude.
// - phases A, B and C each own a phase correction register.
// - each phase power is scaled by one plus gain over two to the 23.
// - one gain setting corrects total active, fundamental active, reactive and apparent power.
// - each phase gain register acts only on its own phase.
// - the threshold is the 8-bit active threshold above 27 zero bits, 18000000h by default.
// - the active offset is added at the scaling of threshold over 8 kHz times 128.
// - the fundamental active offset acts like the total active offset.
// - each phase has its own total and fundamental active offset registers.
// - each phase has a fundamental reactive offset with the active offset scaling.
// - active and reactive results of one phase are presented together.
`timescale 1ns/1ps
`default_nettype none
`include "ppcd_defines.vh"
module ppcd_top
(
  input wire ref_clk,
  input wire arst_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`PPCD_ADDR_W-1:0] reg_addr,
  input wire [`PPCD_DATA_W-1:0] reg_wdata,
  output reg [`PPCD_DATA_W-1:0] reg_rdata,
  output reg reg_rvalid,
  input wire [7:0] active_energy_threshold,
  input wire sample_stb,
  input wire [`PPCD_PWR_W*3-1:0] cur_in,
  input wire [`PPCD_PWR_W*3-1:0] volt_in,
  output reg [`PPCD_PWR_W*3-1:0] cur_aligned,
  output reg [`PPCD_PWR_W*3-1:0] volt_aligned,
  input wire power_stb,
  input wire [`PPCD_PWR_W*3-1:0] total_active_in,
  input wire [`PPCD_PWR_W*3-1:0] fund_active_in,
  input wire [`PPCD_PWR_W*3-1:0] fund_reactive_in,
  input wire [`PPCD_PWR_W*3-1:0] apparent_in,
  output reg [`PPCD_PWR_W*3-1:0] total_active_out,
  output reg [`PPCD_PWR_W*3-1:0] fund_active_out,
  output reg [`PPCD_PWR_W*3-1:0] fund_reactive_out,
  output reg [`PPCD_PWR_W*3-1:0] apparent_out,
  output reg power_valid,
  output reg [`PPCD_THR_ZERO_BITS+7:0] energy_threshold
);
  // register index: 0..2 gain, 3..5 total active offset, 6..8 fund active,
  // 9..11 fund reactive, 12..14 phase correction; 15 means unmapped
  function [3:0] ppcd_decode;
    input [`PPCD_ADDR_W-1:0] a;
    begin
      case (a)
        `PPCD_OFF_A_GAIN: ppcd_decode = 4'h0;
        `PPCD_OFF_B_GAIN: ppcd_decode = 4'h1;
        `PPCD_OFF_C_GAIN: ppcd_decode = 4'h2;
        `PPCD_OFF_A_WOS: ppcd_decode = 4'h3;
        `PPCD_OFF_B_WOS: ppcd_decode = 4'h4;
        `PPCD_OFF_C_WOS: ppcd_decode = 4'h5;
        `PPCD_OFF_A_FWOS: ppcd_decode = 4'h6;
        `PPCD_OFF_B_FWOS: ppcd_decode = 4'h7;
        `PPCD_OFF_C_FWOS: ppcd_decode = 4'h8;
        `PPCD_OFF_A_FVOS: ppcd_decode = 4'h9;
        `PPCD_OFF_B_FVOS: ppcd_decode = 4'hA;
        `PPCD_OFF_C_FVOS: ppcd_decode = 4'hB;
        `PPCD_OFF_A_PH: ppcd_decode = 4'hC;
        `PPCD_OFF_B_PH: ppcd_decode = 4'hD;
        `PPCD_OFF_C_PH: ppcd_decode = 4'hE;
        default: ppcd_decode = 4'hF;
      endcase
    end
  endfunction

  reg [`PPCD_DATA_W-1:0] cal_q [0:14];
  wire [3:0] wr_idx = ppcd_decode(reg_addr);
  integer i;

  // writes land directly in the working registers, used from the next strobe on
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (i = 0; i < 15; i = i + 1)
        cal_q[i] <= `PPCD_REG_RESET;
    end
    else if (reg_wr && wr_idx != 4'hF)
    begin
      if (wr_idx >= 4'hC)
        cal_q[wr_idx] <= {14'h0000, reg_wdata[`PPCD_PH_W-1:0]};
      else
        cal_q[wr_idx] <= reg_wdata;
    end
  end

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 24'h000000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= (wr_idx == 4'hF) ? 24'h000000 : cal_q[wr_idx];
    end
  end

  // threshold: full 8-bit value above 27 zero bits, nothing dropped
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      energy_threshold <= {`PPCD_THR_RESET, 27'h0000000};
    else
      energy_threshold <= {active_energy_threshold, 27'h0000000};
  end

  wire [`PPCD_PWR_W*3-1:0] cur_d;
  wire [`PPCD_PWR_W*3-1:0] volt_d;
  wire [`PPCD_PWR_W*3-1:0] ta_d;
  wire [`PPCD_PWR_W*3-1:0] fa_d;
  wire [`PPCD_PWR_W*3-1:0] fr_d;
  wire [`PPCD_PWR_W*3-1:0] ap_d;

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph = ph + 1)
    begin : g_phase
      ppcd_phase_delay u_delay
      (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sample_stb(sample_stb),
        .cur_in(cur_in[ph*32 +: 32]),
        .volt_in(volt_in[ph*32 +: 32]),
        .correction(cal_q[12+ph][`PPCD_PH_W-1:0]),
        .cur_out(cur_d[ph*32 +: 32]),
        .volt_out(volt_d[ph*32 +: 32])
      );
      // same gain feeds all four powers of the phase
      ppcd_gain_offset u_ta
      (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .in_stb(power_stb),
        .pwr_in(total_active_in[ph*32 +: 32]),
        .gain(cal_q[ph]),
        .offset(cal_q[3+ph]),
        .pwr_out(ta_d[ph*32 +: 32])
      );
      ppcd_gain_offset u_fa
      (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .in_stb(power_stb),
        .pwr_in(fund_active_in[ph*32 +: 32]),
        .gain(cal_q[ph]),
        .offset(cal_q[6+ph]),
        .pwr_out(fa_d[ph*32 +: 32])
      );
      ppcd_gain_offset u_fr
      (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .in_stb(power_stb),
        .pwr_in(fund_reactive_in[ph*32 +: 32]),
        .gain(cal_q[ph]),
        .offset(cal_q[9+ph]),
        .pwr_out(fr_d[ph*32 +: 32])
      );
      ppcd_gain_offset u_ap
      (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .in_stb(power_stb),
        .pwr_in(apparent_in[ph*32 +: 32]),
        .gain(cal_q[ph]),
        .offset(24'h000000),
        .pwr_out(ap_d[ph*32 +: 32])
      );
    end
  endgenerate

  reg power_stb_q;
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      power_stb_q <= 1'b0;
      power_valid <= 1'b0;
      cur_aligned <= 96'h0;
      volt_aligned <= 96'h0;
      total_active_out <= 96'h0;
      fund_active_out <= 96'h0;
      fund_reactive_out <= 96'h0;
      apparent_out <= 96'h0;
    end
    else
    begin
      cur_aligned <= cur_d;
      volt_aligned <= volt_d;
      power_stb_q <= power_stb;
      power_valid <= power_stb_q;
      if (power_stb_q)
      begin
        // all powers of every phase are updated in the same cycle
        total_active_out <= ta_d;
        fund_active_out <= fa_d;
        fund_reactive_out <= fr_d;
        apparent_out <= ap_d;
      end
    end
  end
endmodule // ppcd_top
`default_nettype wire

// ---- hdl/ppcd_defines.vh ----
// register offsets, field widths and constants for the phase power calibration datapath
`ifndef PPCD_DEFINES_VH
`define PPCD_DEFINES_VH
`define PPCD_ADDR_W 16
`define PPCD_DATA_W 24
`define PPCD_PH_W 10
`define PPCD_PWR_W 32
`define PPCD_OFF_A_GAIN 16'h4389
`define PPCD_OFF_A_WOS 16'h438A
`define PPCD_OFF_B_GAIN 16'h438B
`define PPCD_OFF_B_WOS 16'h438C
`define PPCD_OFF_C_GAIN 16'h438D
`define PPCD_OFF_C_WOS 16'h438E
`define PPCD_OFF_A_FWOS 16'h43A2
`define PPCD_OFF_B_FWOS 16'h43A3
`define PPCD_OFF_C_FWOS 16'h43A4
`define PPCD_OFF_A_FVOS 16'h43A5
`define PPCD_OFF_B_FVOS 16'h43A6
`define PPCD_OFF_C_FVOS 16'h43A7
`define PPCD_OFF_A_PH 16'hE614
`define PPCD_OFF_B_PH 16'hE615
`define PPCD_OFF_C_PH 16'hE616
`define PPCD_GAIN_FRAC 23
`define PPCD_PH_DIR_BIT 9
`define PPCD_THR_ZERO_BITS 27
`define PPCD_THR_RESET 8'h03
`define PPCD_OFFSET_SHIFT 7
`define PPCD_REG_RESET 24'h000000
`define PPCD_PH_RESET 10'h000
`define PPCD_DELAY_DEPTH 512
`endif

// ---- hdl/ppcd_phase_delay.v ----
// per-phase signed sample delay of the current or voltage channel for phase compensation
`timescale 1ns/1ps
`default_nettype none
`include "ppcd_defines.vh"
module ppcd_phase_delay
(
  input wire ref_clk,
  input wire arst_n,
  input wire sample_stb,
  input wire [`PPCD_PWR_W-1:0] cur_in,
  input wire [`PPCD_PWR_W-1:0] volt_in,
  input wire [`PPCD_PH_W-1:0] correction,
  output reg [`PPCD_PWR_W-1:0] cur_out,
  output reg [`PPCD_PWR_W-1:0] volt_out
);
  reg [`PPCD_PWR_W-1:0] cur_mem [0:`PPCD_DELAY_DEPTH-1];
  reg [`PPCD_PWR_W-1:0] volt_mem [0:`PPCD_DELAY_DEPTH-1];
  reg [8:0] wr_q;
  wire [8:0] mag = correction[8:0];
  wire dir = correction[`PPCD_PH_DIR_BIT];
  wire [8:0] rd = wr_q - mag;
  // one step is one sample at 1.024 MHz: 360*f/1.024MHz degrees
  always @(posedge ref_clk)
  begin
    if (sample_stb)
    begin
      cur_mem[wr_q] <= cur_in;
      volt_mem[wr_q] <= volt_in;
    end
  end
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_q <= 9'h000;
      cur_out <= 32'h00000000;
      volt_out <= 32'h00000000;
    end
    else if (sample_stb)
    begin
      wr_q <= wr_q + 9'h001;
      // positive error delays voltage, negative error delays current, zero magnitude delays neither
      if (mag == 9'h000)
      begin
        cur_out <= cur_in;
        volt_out <= volt_in;
      end
      else if (dir)
      begin
        cur_out <= cur_in;
        volt_out <= volt_mem[rd];
      end
      else
      begin
        cur_out <= cur_mem[rd];
        volt_out <= volt_in;
      end
    end
  end
endmodule // ppcd_phase_delay
`default_nettype wire

// ---- hdl/ppcd_gain_offset.v ----
// gain scaling and offset addition of one power word
`timescale 1ns/1ps
`default_nettype none
`include "ppcd_defines.vh"
module ppcd_gain_offset
(
  input wire ref_clk,
  input wire arst_n,
  input wire in_stb,
  input wire [`PPCD_PWR_W-1:0] pwr_in,
  input wire [`PPCD_DATA_W-1:0] gain,
  input wire [`PPCD_DATA_W-1:0] offset,
  output reg [`PPCD_PWR_W-1:0] pwr_out
);
  wire signed [`PPCD_PWR_W-1:0] p = pwr_in;
  wire signed [`PPCD_DATA_W-1:0] g = gain;
  wire signed [`PPCD_DATA_W-1:0] o = offset;
  wire signed [56:0] prod = p * g;
  wire signed [56:0] scaled = (prod >>> `PPCD_GAIN_FRAC) + p;
  wire signed [56:0] os = o >>> `PPCD_OFFSET_SHIFT;
  wire signed [56:0] sum = scaled + os;
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pwr_out <= 32'h00000000;
    else if (in_stb)
      pwr_out <= sum[31:0];
  end
endmodule // ppcd_gain_offset
`default_nettype wire

// ---- tb/ppcd_props.sv ----
// port assertions of the calibration datapath top
`timescale 1ns/1ps
`default_nettype none
`include "ppcd_defines.vh"
module ppcd_props
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [`PPCD_ADDR_W-1:0] reg_addr,
  input wire logic [`PPCD_DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [7:0] active_energy_threshold,
  input wire logic power_stb,
  input wire logic [`PPCD_PWR_W*3-1:0] total_active_out,
  input wire logic [`PPCD_PWR_W*3-1:0] fund_reactive_out,
  input wire logic power_valid,
  input wire logic [`PPCD_THR_ZERO_BITS+7:0] energy_threshold
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence rd_req;
    reg_rd;
  endsequence
  sequence rd_ans;
    reg_rvalid;
  endsequence
  sequence unm_rd;
    reg_rd && reg_addr == 16'h0000;
  endsequence
  AST_RD_ANSWER: assert property (rd_req |=> rd_ans)
    else $error("read not answered");
  AST_RD_CAUSE: assert property (rd_ans |-> $past(reg_rd))
    else $error("read answer without request");
  AST_RD_HOLD: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without read");
  AST_UNMAPPED: assert property (unm_rd |=> reg_rdata == 24'h000000)
    else $error("unmapped read not zero");
  AST_THR: assert property ($past(arst_n) |->
    energy_threshold == {$past(active_energy_threshold), 27'h0000000})
    else $error("threshold not formed from level");
  AST_PV_LAT: assert property (power_stb |-> ##2 power_valid)
    else $error("power result late");
  AST_PV_CAUSE: assert property (power_valid |-> $past(power_stb, 2))
    else $error("power valid without strobe");
  AST_OUT_HOLD: assert property (!power_valid |->
    $stable(total_active_out) && $stable(fund_reactive_out))
    else $error("power outputs moved without valid");
endmodule // ppcd_props
bind ppcd_top ppcd_props u_props (.ref_clk(ref_clk), .arst_n(arst_n), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .active_energy_threshold(active_energy_threshold), .power_stb(power_stb),
  .total_active_out(total_active_out), .fund_reactive_out(fund_reactive_out),
  .power_valid(power_valid), .energy_threshold(energy_threshold));
`default_nettype wire

// ---- tb/tb_ppcd_top.sv ----
// self-checking bench of the calibration datapath top
`timescale 1ns/1ps
`default_nettype none
`include "ppcd_defines.vh"
module tb_ppcd_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic power_stb = 1'b0;
  logic sample_stb = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [23:0] reg_wdata = 24'h000000;
  logic [7:0] thr = 8'h03;
  logic [95:0] cur_in = 96'h0, volt_in = 96'h0, ta_in = 96'h0, fa_in = 96'h0;
  logic [95:0] fr_in = 96'h0, ap_in = 96'h0, cur_al, volt_al, ta_o, fa_o, fr_o, ap_o;
  logic [23:0] reg_rdata;
  logic reg_rvalid, power_valid;
  logic [34:0] energy_threshold;
  int bad_count = 0;
  int samples_checked = 0;
  logic [23:0] rv [15];
  logic [15:0] adr [15] = '{`PPCD_OFF_A_GAIN, `PPCD_OFF_A_WOS, `PPCD_OFF_B_GAIN,
    `PPCD_OFF_B_WOS, `PPCD_OFF_C_GAIN, `PPCD_OFF_C_WOS, `PPCD_OFF_A_FWOS, `PPCD_OFF_B_FWOS,
    `PPCD_OFF_C_FWOS, `PPCD_OFF_A_FVOS, `PPCD_OFF_B_FVOS, `PPCD_OFF_C_FVOS, `PPCD_OFF_A_PH,
    `PPCD_OFF_B_PH, `PPCD_OFF_C_PH};
  always #12.5 ref_clk = ~ref_clk;
  ppcd_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .active_energy_threshold(thr), .sample_stb(sample_stb),
    .cur_in(cur_in), .volt_in(volt_in), .cur_aligned(cur_al), .volt_aligned(volt_al),
    .power_stb(power_stb), .total_active_in(ta_in), .fund_active_in(fa_in),
    .fund_reactive_in(fr_in), .apparent_in(ap_in), .total_active_out(ta_o),
    .fund_active_out(fa_o), .fund_reactive_out(fr_o), .apparent_out(ap_o),
    .power_valid(power_valid), .energy_threshold(energy_threshold));
  // samples keep flowing so the phase compensation path is exercised
  always @(posedge ref_clk)
  begin
    sample_stb <= ~sample_stb;
    cur_in <= {$urandom, $urandom, $urandom};
    volt_in <= {$urandom, $urandom, $urandom};
  end
  // reference model of the phase compensation, fed by snooped register writes
  logic [9:0] phm [3];
  logic [31:0] hc [3][512];
  logic [31:0] hv [3][512];
  logic [8:0] nq;
  logic [95:0] ec_d, ev_d, ec_al, ev_al;
  int cnt;
  int mp;
  int cp;
  always @(posedge ref_clk)
  begin
    if (!arst_n)
    begin
      nq <= 9'h000;
      cnt <= 0;
      ec_d <= 96'h0;
      ev_d <= 96'h0;
      ec_al <= 96'h0;
      ev_al <= 96'h0;
      for (mp = 0; mp < 3; mp++)
        phm[mp] <= 10'h000;
    end
    else
    begin
      ec_al <= ec_d;
      ev_al <= ev_d;
      if (sample_stb)
      begin
        nq <= nq + 9'h001;
        if (cnt < 40)
          cnt <= cnt + 1;
        for (mp = 0; mp < 3; mp++)
        begin
          hc[mp][nq] <= cur_in[32*mp +: 32];
          hv[mp][nq] <= volt_in[32*mp +: 32];
          ec_d[32*mp +: 32] <= (phm[mp][8:0] != 9'h000 && !phm[mp][9]) ?
            hc[mp][nq - phm[mp][8:0]] : cur_in[32*mp +: 32];
          ev_d[32*mp +: 32] <= (phm[mp][8:0] != 9'h000 && phm[mp][9]) ?
            hv[mp][nq - phm[mp][8:0]] : volt_in[32*mp +: 32];
        end
      end
      for (mp = 0; mp < 3; mp++)
        if (reg_wr && reg_addr == adr[12+mp])
          phm[mp] <= reg_wdata[9:0];
    end
  end
  // aligned samples stand one cycle after the compensation stage
  always @(negedge ref_clk)
  begin
    if (arst_n && cnt > 33)
    begin
      for (cp = 0; cp < 3; cp++)
      begin
        chk(cur_al[32*cp +: 32], ec_al[32*cp +: 32]);
        chk(volt_al[32*cp +: 32], ev_al[32*cp +: 32]);
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] corr(input logic [31:0] p, input logic [23:0] g,
    input logic [23:0] o);
    logic signed [63:0] m;
    m = $signed(p) * $signed(g);
    return p + 32'(m >>> 23) + 32'($signed(o) >>> 7);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [23:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [23:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid, reg_rdata}, {7'h01, e});
  endtask
  task automatic pw();
    int i;
    @(posedge ref_clk);
    power_stb <= 1'b1;
    ta_in <= {$urandom, $urandom, $urandom};
    fa_in <= {$urandom, $urandom, $urandom};
    fr_in <= {$urandom, $urandom, $urandom};
    ap_in <= {$urandom, $urandom, $urandom};
    @(posedge ref_clk);
    power_stb <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({31'h0, power_valid}, 32'h00000001);
    for (i = 0; i < 3; i++)
    begin
      chk(ta_o[32*i +: 32], corr(ta_in[32*i +: 32], rv[2*i], rv[2*i+1]));
      chk(fa_o[32*i +: 32], corr(fa_in[32*i +: 32], rv[2*i], rv[6+i]));
      chk(fr_o[32*i +: 32], corr(fr_in[32*i +: 32], rv[2*i], rv[9+i]));
      chk(ap_o[32*i +: 32], corr(ap_in[32*i +: 32], rv[2*i], 24'h000000));
    end
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    int i;
    int k;
    void'($urandom(13));
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (i = 0; i < 15; i++)
    begin
      rv[i] = 24'h000000;
      rd(adr[i], 24'h000000);
    end
    rd(16'h0000, 24'h000000);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(energy_threshold[31:0], 32'h18000000);
    chk({29'h0, energy_threshold[34:32]}, 32'h00000000);
    pw();
    $display("reset test done");
    for (k = 0; k < 4; k++)
    begin
      for (i = 0; i < 15; i++)
      begin
        rv[i] = 24'($urandom);
        // magnitudes stay within the sample history the model has seen
        if (i > 11)
          rv[i] = rv[i] & 24'hFFFE1F;
        if (k == 1 && i == 12)
          rv[i] = 24'h000200;
        if (k == 3 && i == 0)
          rv[i] = 24'h800000;
        if (k == 2 && (i == 2 || i == 4))
          rv[i] = rv[0];
        wr(adr[i], rv[i]);
      end
      wr(16'h0000, 24'($urandom));
      for (i = 0; i < 15; i++)
        rd(adr[i], (i > 11) ? (rv[i] & 24'h0003FF) : rv[i]);
      rd(16'h0000, 24'h000000);
      pw();
      pw();
      @(posedge ref_clk);
      thr <= 8'($urandom);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(energy_threshold[31:0], {thr[4:0], 27'h0000000});
      chk({29'h0, energy_threshold[34:32]}, {29'h0, thr[7:5]});
      $display("calibration test %0d done", k);
    end
    test_done();
  end
  initial
  begin
    #1000000;
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule // tb_ppcd_top
`default_nettype wire
